/* logic/pfbu_pkg.sv */
// package of constants and types for the program flow branch unit
package pfbu_pkg;
    // ==========================================================
    // register map, apb byte addresses
    localparam logic [7:0]  OFS_IP      = 8'h00;
    localparam logic [7:0]  OFS_LC0     = 8'h04;
    localparam logic [7:0]  OFS_LC1     = 8'h08;
    localparam logic [7:0]  OFS_PFX     = 8'h0C;
    localparam logic [7:0]  OFS_IPS     = 8'h10;
    localparam logic [7:0]  OFS_CTRL    = 8'h14;
    localparam logic [7:0]  OFS_STATUS  = 8'h18;
    // ==========================================================
    // field positions
    localparam int          CTRL_RUN    = 0;
    localparam int          ST_CARRY    = 0;
    localparam int          ST_EQUALS   = 1;
    localparam int          ST_ZERO     = 2;
    localparam int          ST_SIGN     = 3;
    localparam int          ST_PFXV     = 4;
    localparam int          ST_ILLEGAL  = 5;
    // ==========================================================
    // reset values and fixed codes
    localparam logic [15:0] PC_RST      = 16'h0000;
    localparam logic [15:0] LC_RST      = 16'h0000;
    localparam logic [7:0]  PFX_RST     = 8'h00;
    localparam logic [1:0]  IPS_RST     = 2'h0;
    localparam logic [1:0]  IPS_RETI    = 2'h3;
    localparam logic        RUN_RST     = 1'b1;
    // ==========================================================
    // instruction classes
    typedef enum logic [2:0] {PFBU_OP_NOP, PFBU_OP_PREFIX, PFBU_OP_JUMP, PFBU_OP_CALL,
                              PFBU_OP_RET, PFBU_OP_RETI, PFBU_OP_DJNZ} pfbu_op_e;
    typedef enum logic [2:0] {PFBU_CC_ALWAYS, PFBU_CC_C, PFBU_CC_NC, PFBU_CC_Z,
                              PFBU_CC_NZ, PFBU_CC_S, PFBU_CC_E, PFBU_CC_NE} pfbu_cond_e;
    typedef enum logic [1:0] {PFBU_SRC_IMM, PFBU_SRC_REG16, PFBU_SRC_REG8} pfbu_src_e;
endpackage

/* logic/pfbu_cond.sv */
// branch condition evaluation from status flags and accumulator
`timescale 1ns/10ps
module pfbu_cond #(
    parameter int ACC_W = 16
) (
    input  wire logic [ACC_W-1:0]       acc_value,
    input  wire logic                   carry_flag,
    input  wire logic                   equals_flag,
    input  wire pfbu_pkg::pfbu_cond_e   cond,
    output logic                        zero_flag,
    output logic                        sign_flag,
    output logic                        cond_true
);
    if (ACC_W < 2) begin : g_bad_width
        $error("pfbu_cond: ACC_W must be at least 2");
    end

    assign zero_flag = (acc_value == '0);
    assign sign_flag = acc_value[ACC_W-1];

    always_comb begin
        unique case (cond)
            pfbu_pkg::PFBU_CC_ALWAYS: cond_true = 1'b1;
            pfbu_pkg::PFBU_CC_C:      cond_true = carry_flag;
            pfbu_pkg::PFBU_CC_NC:     cond_true = !carry_flag;
            pfbu_pkg::PFBU_CC_Z:      cond_true = zero_flag;
            pfbu_pkg::PFBU_CC_NZ:     cond_true = !zero_flag;
            pfbu_pkg::PFBU_CC_S:      cond_true = sign_flag;
            pfbu_pkg::PFBU_CC_E:      cond_true = equals_flag;
            pfbu_pkg::PFBU_CC_NE:     cond_true = !equals_flag;
        endcase
    end
endmodule

/* logic/pfbu_loopcnt.sv */
// bank of loop counters with software load and decrement
`timescale 1ns/10ps
module pfbu_loopcnt #(
    parameter int N = 2,
    parameter int W = 16
) (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic                 dec_en,
    input  wire logic [$clog2(N)-1:0] dec_sel,
    input  wire logic                 wr_en,
    input  wire logic [$clog2(N)-1:0] wr_sel,
    input  wire logic [W-1:0]         wr_data,
    output logic [N*W-1:0]            count_flat,
    output logic [W-1:0]              dec_result
);
    if (N < 2 || W != 16) begin : g_bad_cfg
        $error("pfbu_loopcnt: needs N >= 2 and W == 16");
    end

    logic [W-1:0] count_reg [N];
    logic [W-1:0] count_next [N];

    assign dec_result = count_reg[dec_sel] - W'(1);

    for (genvar i = 0; i < N; i++) begin : g_cnt
        always_comb begin
            count_next[i] = count_reg[i];
            if (wr_en && wr_sel == i) begin
                count_next[i] = wr_data;
            end
            // the decrement wins over a software load in the same cycle
            if (dec_en && dec_sel == i) begin
                count_next[i] = dec_result;
            end
        end
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                count_reg[i] <= pfbu_pkg::LC_RST;
            end else begin
                count_reg[i] <= count_next[i];
            end
        end
        assign count_flat[i*W +: W] = count_reg[i];
    end
endmodule

/* logic/pfbu_top.sv */
// program flow branch unit: jump, call, return and loop sequencing with apb registers
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module pfbu_top #(
    parameter int ACC_W = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   instr_valid,
    output logic                        instr_ready,
    input  wire pfbu_pkg::pfbu_op_e     instr_op,
    input  wire pfbu_pkg::pfbu_cond_e   instr_cond,
    input  wire pfbu_pkg::pfbu_src_e    instr_src,
    input  wire logic                   instr_lc_sel,
    input  wire logic [7:0]             instr_imm8,
    input  wire logic [15:0]            instr_reg16,
    input  wire logic [7:0]             instr_reg8,
    input  wire logic [ACC_W-1:0]       acc_value,
    input  wire logic                   carry_flag,
    input  wire logic                   equals_flag,
    output logic                        stack_push,
    output logic [15:0]                 stack_push_data,
    output logic                        stack_pop,
    input  wire logic [15:0]            stack_pop_data,
    output logic [15:0]                 prog_addr,
    output logic [1:0]                  interrupt_priority_state
);
    // ==========================================================
    // state
    logic [15:0] pc_reg,      pc_next;
    logic [7:0]  pfx_reg,     pfx_next;
    logic        pfxv_reg,    pfxv_next;
    logic [1:0]  ips_reg,     ips_next;
    logic        run_reg,     run_next;
    logic        illegal_reg, illegal_next;
    logic [31:0] rdata_reg,   rdata_next;

    logic        zero_flag;
    logic        sign_flag;
    logic        cond_true;
    logic [31:0] lc_flat;
    logic [15:0] lc_dec;
    logic        lc_dec_en;
    logic        lc_wr_en;
    logic        lc_wr_sel;
    logic [15:0] ip_value;
    logic [15:0] target;
    logic        exec;
    logic        legal;
    logic        apb_setup;
    logic        apb_wr;
    logic        apb_hit;

    // ==========================================================
    // helpers
    pfbu_cond #(
        .ACC_W       (ACC_W)
    ) u_cond (
        .acc_value   (acc_value),
        .carry_flag  (carry_flag),
        .equals_flag (equals_flag),
        .cond        (instr_cond),
        .zero_flag   (zero_flag),
        .sign_flag   (sign_flag),
        .cond_true   (cond_true)
    );

    pfbu_loopcnt #(
        .N          (2),
        .W          (16)
    ) u_loopcnt (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .dec_en     (lc_dec_en),
        .dec_sel    (instr_lc_sel),
        .wr_en      (lc_wr_en),
        .wr_sel     (lc_wr_sel),
        .wr_data    (pwdata[15:0]),
        .count_flat (lc_flat),
        .dec_result (lc_dec)
    );

    // ==========================================================
    // apb decode, zero wait state
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite;
    assign apb_hit   = paddr inside {pfbu_pkg::OFS_IP, pfbu_pkg::OFS_LC0, pfbu_pkg::OFS_LC1,
                                     pfbu_pkg::OFS_PFX, pfbu_pkg::OFS_IPS, pfbu_pkg::OFS_CTRL,
                                     pfbu_pkg::OFS_STATUS};
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !apb_hit;
    assign lc_wr_en  = apb_wr && (paddr == pfbu_pkg::OFS_LC0 || paddr == pfbu_pkg::OFS_LC1);
    assign lc_wr_sel = (paddr == pfbu_pkg::OFS_LC1);
    assign prdata    = rdata_reg;

    // ==========================================================
    // execution datapath
    assign ip_value    = pc_reg + 16'h0001;
    assign exec        = instr_valid && run_reg;
    assign instr_ready = run_reg;
    assign prog_addr   = pc_reg;
    assign interrupt_priority_state = ips_reg;

    always_comb begin
        unique case (instr_src)
            pfbu_pkg::PFBU_SRC_IMM: begin
                if (pfxv_reg) begin
                    target = {pfx_reg, instr_imm8};
                end else begin
                    target = ip_value + {{8{instr_imm8[7]}}, instr_imm8};
                end
            end
            pfbu_pkg::PFBU_SRC_REG16: target = instr_reg16;
            pfbu_pkg::PFBU_SRC_REG8:  target = {(pfxv_reg ? pfx_reg : 8'h00), instr_reg8};
            default:                  target = ip_value;
        endcase
    end

    always_comb begin
        legal = 1'b1;
        // equals conditions refuse register destinations
        if ((instr_cond == pfbu_pkg::PFBU_CC_E || instr_cond == pfbu_pkg::PFBU_CC_NE) &&
            instr_src != pfbu_pkg::PFBU_SRC_IMM) begin
            legal = 1'b0;
        end
        // returns exist only for always, c, nc, z, nz and s
        if ((instr_op == pfbu_pkg::PFBU_OP_RET || instr_op == pfbu_pkg::PFBU_OP_RETI) &&
            (instr_cond == pfbu_pkg::PFBU_CC_E || instr_cond == pfbu_pkg::PFBU_CC_NE)) begin
            legal = 1'b0;
        end
        if (instr_op == pfbu_pkg::PFBU_OP_CALL && instr_cond != pfbu_pkg::PFBU_CC_ALWAYS) begin
            legal = 1'b0;
        end
    end

    assign lc_dec_en       = exec && instr_op == pfbu_pkg::PFBU_OP_DJNZ;
    assign stack_push      = exec && legal && instr_op == pfbu_pkg::PFBU_OP_CALL;
    assign stack_push_data = ip_value;
    assign stack_pop       = exec && legal && cond_true &&
                             (instr_op == pfbu_pkg::PFBU_OP_RET || instr_op == pfbu_pkg::PFBU_OP_RETI);

    // ==========================================================
    // next state
    always_comb begin
        pc_next      = pc_reg;
        pfx_next     = pfx_reg;
        pfxv_next    = pfxv_reg;
        ips_next     = ips_reg;
        run_next     = run_reg;
        illegal_next = illegal_reg;
        rdata_next   = rdata_reg;
        if (apb_wr && paddr == pfbu_pkg::OFS_PFX) begin
            pfx_next  = pwdata[7:0];
            pfxv_next = 1'b1;
        end
        if (apb_wr && paddr == pfbu_pkg::OFS_IPS) begin
            ips_next = pwdata[1:0];
        end
        if (apb_wr && paddr == pfbu_pkg::OFS_CTRL) begin
            run_next = pwdata[pfbu_pkg::CTRL_RUN];
        end
        if (apb_wr && paddr == pfbu_pkg::OFS_STATUS && pwdata[pfbu_pkg::ST_ILLEGAL]) begin
            illegal_next = 1'b0;
        end
        if (exec) begin
            pc_next   = ip_value;
            pfxv_next = 1'b0;
            if (!legal) begin
                illegal_next = 1'b1;
            end
            unique case (instr_op)
                pfbu_pkg::PFBU_OP_NOP: begin
                end
                pfbu_pkg::PFBU_OP_PREFIX: begin
                    pfx_next  = instr_imm8;
                    pfxv_next = 1'b1;
                end
                pfbu_pkg::PFBU_OP_JUMP, pfbu_pkg::PFBU_OP_CALL: begin
                    if (legal && cond_true) begin
                        pc_next = target;
                    end
                end
                pfbu_pkg::PFBU_OP_RET, pfbu_pkg::PFBU_OP_RETI: begin
                    if (legal && cond_true) begin
                        pc_next = stack_pop_data;
                        if (instr_op == pfbu_pkg::PFBU_OP_RETI) begin
                            ips_next = pfbu_pkg::IPS_RETI;
                        end
                    end
                end
                pfbu_pkg::PFBU_OP_DJNZ: begin
                    if (lc_dec != 16'h0000) begin
                        pc_next = target;
                    end
                end
                default: begin
                end
            endcase
        end
        if (apb_setup) begin
            unique case (paddr)
                pfbu_pkg::OFS_IP:     rdata_next = {16'h0000, ip_value};
                pfbu_pkg::OFS_LC0:    rdata_next = {16'h0000, lc_flat[15:0]};
                pfbu_pkg::OFS_LC1:    rdata_next = {16'h0000, lc_flat[31:16]};
                pfbu_pkg::OFS_PFX:    rdata_next = {24'h000000, pfx_reg};
                pfbu_pkg::OFS_IPS:    rdata_next = {30'h0, ips_reg};
                pfbu_pkg::OFS_CTRL:   rdata_next = {31'h0, run_reg};
                pfbu_pkg::OFS_STATUS: rdata_next = {26'h0, illegal_reg, pfxv_reg, sign_flag,
                                                    zero_flag, equals_flag, carry_flag};
                default:              rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pc_reg      <= pfbu_pkg::PC_RST;
            pfx_reg     <= pfbu_pkg::PFX_RST;
            pfxv_reg    <= 1'b0;
            ips_reg     <= pfbu_pkg::IPS_RST;
            run_reg     <= pfbu_pkg::RUN_RST;
            illegal_reg <= 1'b0;
            rdata_reg   <= 32'h00000000;
        end else begin
            pc_reg      <= pc_next;
            pfx_reg     <= pfx_next;
            pfxv_reg    <= pfxv_next;
            ips_reg     <= ips_next;
            run_reg     <= run_next;
            illegal_reg <= illegal_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic plain_exec;
    assign plain_exec = exec && !(apb_wr && paddr == pfbu_pkg::OFS_PFX);
    logic jump_taken;
    assign jump_taken = exec && legal && cond_true && instr_op == pfbu_pkg::PFBU_OP_JUMP;

    AST_IP_READ: assert property (
        apb_setup && paddr == pfbu_pkg::OFS_IP |=> prdata[15:0] == $past(pc_reg) + 16'h0001)
        else $error("ip read is not current address plus one");

    AST_REL_JUMP: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_JUMP && instr_cond == pfbu_pkg::PFBU_CC_ALWAYS &&
        instr_src == pfbu_pkg::PFBU_SRC_IMM && !pfxv_reg
        |=> pc_reg == $past(pc_reg) + 16'h0001 + {{8{$past(instr_imm8[7])}}, $past(instr_imm8)})
        else $error("relative jump target wrong");

    AST_REG16_JUMP: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_JUMP && instr_cond == pfbu_pkg::PFBU_CC_ALWAYS &&
        instr_src == pfbu_pkg::PFBU_SRC_REG16 |=> pc_reg == $past(instr_reg16))
        else $error("register jump target wrong");

    AST_PFX_LONG: assert property (
        plain_exec && instr_op == pfbu_pkg::PFBU_OP_PREFIX ##1
        exec && instr_op == pfbu_pkg::PFBU_OP_JUMP && instr_cond == pfbu_pkg::PFBU_CC_ALWAYS &&
        instr_src != pfbu_pkg::PFBU_SRC_REG16
        |=> pc_reg[15:8] == $past(instr_imm8, 2))
        else $error("prefix high byte not used");

    AST_PFX_ONCE: assert property (
        plain_exec && instr_op != pfbu_pkg::PFBU_OP_PREFIX |=> !pfxv_reg)
        else $error("prefix outlived the following instruction");

    AST_EQ_REG: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_JUMP && instr_cond inside {pfbu_pkg::PFBU_CC_E,
        pfbu_pkg::PFBU_CC_NE} && instr_src != pfbu_pkg::PFBU_SRC_IMM
        |=> pc_reg == $past(pc_reg) + 16'h0001 && illegal_reg)
        else $error("equals jump took a register destination");

    AST_NOT_TAKEN: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_JUMP && !cond_true
        |=> pc_reg == $past(pc_reg) + 16'h0001)
        else $error("untaken jump did not fall through");

    AST_CALL_PUSH: assert property (
        stack_push |-> stack_push_data == pc_reg + 16'h0001 ##1 pc_reg == $past(target))
        else $error("call push or target wrong");

    AST_RET_FALSE: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_RET && !cond_true
        |-> !stack_pop ##1 pc_reg == $past(pc_reg) + 16'h0001)
        else $error("false return changed state");

    AST_RETI_TRUE: assert property (
        stack_pop && instr_op == pfbu_pkg::PFBU_OP_RETI
        |=> interrupt_priority_state == 2'h3 && pc_reg == $past(stack_pop_data))
        else $error("reti did not restore priority and address");

    AST_RETI_FALSE: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_RETI && !cond_true && !apb_wr
        |=> $stable(interrupt_priority_state))
        else $error("false reti changed priority bits");

    AST_DJNZ: assert property (
        lc_dec_en && lc_dec == 16'h0000 |=> pc_reg == $past(pc_reg) + 16'h0001)
        else $error("djnz branched on zero count");

    AST_FLAGS: assert property (
        apb_setup && paddr == pfbu_pkg::OFS_STATUS
        |=> prdata[pfbu_pkg::ST_ZERO] == ($past(acc_value) == '0) &&
            prdata[pfbu_pkg::ST_SIGN] == $past(acc_value[ACC_W-1]))
        else $error("zero or sign flag wrong");

    AST_REG8_JUMP: assert property (
        jump_taken && instr_src == pfbu_pkg::PFBU_SRC_REG8 && pfxv_reg
        |=> pc_reg == {$past(pfx_reg), $past(instr_reg8)})
        else $error("byte register jump lost prefix");

    AST_COND_REG16: assert property (
        jump_taken && instr_src == pfbu_pkg::PFBU_SRC_REG16 |=> pc_reg == $past(instr_reg16))
        else $error("conditional register jump target wrong");

    AST_DJNZ_REG: assert property (
        lc_dec_en && lc_dec != 16'h0000 && instr_src == pfbu_pkg::PFBU_SRC_REG16
        |=> pc_reg == $past(instr_reg16))
        else $error("djnz register loop address ignored");

    AST_DJNZ_FAR: assert property (
        lc_dec_en && lc_dec != 16'h0000 && instr_src == pfbu_pkg::PFBU_SRC_IMM && pfxv_reg
        |=> pc_reg == {$past(pfx_reg), $past(instr_imm8)})
        else $error("far djnz target wrong");

    AST_LC_DEC: assert property (
        lc_dec_en && !instr_lc_sel && !lc_wr_en
        |=> lc_flat[15:0] == $past(lc_flat[15:0]) - 16'h0001 && $stable(lc_flat[31:16]))
        else $error("loop counters not separate");

    AST_RET_TRUE: assert property (
        stack_pop && instr_op == pfbu_pkg::PFBU_OP_RET |=> pc_reg == $past(stack_pop_data))
        else $error("ret did not resume at popped address");

    AST_RETI_HOLD: assert property (
        exec && instr_op == pfbu_pkg::PFBU_OP_RETI && !cond_true
        |-> !stack_pop ##1 pc_reg == $past(pc_reg) + 16'h0001)
        else $error("false reti popped or jumped");

    AST_RUN_HOLD: assert property (
        instr_valid && !instr_ready |=> $stable(pc_reg))
        else $error("stopped core advanced");

    AST_PFX_ARM: assert property (
        apb_wr && paddr == pfbu_pkg::OFS_PFX && !exec |=> pfxv_reg && pfx_reg == $past(pwdata[7:0]))
        else $error("prefix write did not arm");
endmodule

/* dv/pfbu_stack_model.sv */
// stack storage model answering the push and pop strobes of the branch unit
`timescale 1ns/10ps
module pfbu_stack_model (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        stack_push,
    input  wire logic [15:0] stack_push_data,
    input  wire logic        stack_pop,
    output logic [15:0]      stack_pop_data,
    output int               depth
);
    logic [15:0] mem [0:15];
    logic [15:0] last;
    // an empty stack shows the inverse of the last word, never a stale copy
    assign stack_pop_data = (depth > 0) ? mem[depth-1] : ~last;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            depth <= 0;
            last  <= 16'h0000;
        end else if (stack_push && depth < 16) begin
            mem[depth] <= stack_push_data;
            depth      <= depth + 1;
        end else if (stack_pop && depth > 0) begin
            last  <= mem[depth-1];
            depth <= depth - 1;
        end
    end
endmodule

/* dv/tb_top.sv */
// self-checking testbench of the program flow branch unit
`timescale 1ns/10ps
module tb_top;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic instr_valid = 0, instr_lc_sel = 0, carry_flag = 0, equals_flag = 0;
    logic instr_ready, stack_push, stack_pop;
    logic [7:0]  paddr = 0, instr_imm8 = 0, instr_reg8 = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] instr_reg16 = 0, acc_value = 0, stack_push_data, stack_pop_data, prog_addr, pa, ret;
    logic [1:0]  interrupt_priority_state;
    int          depth, mismatches = 0, check_count = 0, cycles = 0;
    localparam pfbu_pkg::pfbu_op_e   JMP = pfbu_pkg::PFBU_OP_JUMP, CALL = pfbu_pkg::PFBU_OP_CALL;
    localparam pfbu_pkg::pfbu_op_e   RET = pfbu_pkg::PFBU_OP_RET, RETI = pfbu_pkg::PFBU_OP_RETI;
    localparam pfbu_pkg::pfbu_op_e   DJNZ = pfbu_pkg::PFBU_OP_DJNZ, PFX = pfbu_pkg::PFBU_OP_PREFIX;
    localparam pfbu_pkg::pfbu_cond_e ALW = pfbu_pkg::PFBU_CC_ALWAYS;
    localparam pfbu_pkg::pfbu_src_e  IMM = pfbu_pkg::PFBU_SRC_IMM, R16 = pfbu_pkg::PFBU_SRC_REG16;
    localparam pfbu_pkg::pfbu_src_e  R8 = pfbu_pkg::PFBU_SRC_REG8;
    pfbu_pkg::pfbu_op_e   instr_op = pfbu_pkg::PFBU_OP_NOP;
    pfbu_pkg::pfbu_cond_e instr_cond = ALW;
    pfbu_pkg::pfbu_src_e  instr_src = IMM;

    pfbu_top uut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .instr_valid, .instr_ready, .instr_op, .instr_cond, .instr_src, .instr_lc_sel, .instr_imm8,
        .instr_reg16, .instr_reg8, .acc_value, .carry_flag, .equals_flag, .stack_push, .stack_push_data,
        .stack_pop, .stack_pop_data, .prog_addr, .interrupt_priority_state);
    pfbu_stack_model stk (.core_clk, .rstn, .stack_push, .stack_push_data, .stack_pop, .stack_pop_data, .depth);

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic stop_test();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic ins(pfbu_pkg::pfbu_op_e op, pfbu_pkg::pfbu_cond_e cc, pfbu_pkg::pfbu_src_e s,
                       logic [7:0] i8, logic [15:0] r16);
        instr_op <= op;
        instr_cond <= cc;
        instr_src <= s;
        instr_imm8 <= i8;
        instr_reg16 <= r16;
        instr_reg8 <= r16[7:0];
        instr_valid <= 1;
        @(posedge core_clk);
    endtask
    // executes one instruction, then compares the address it lands on
    task automatic go(pfbu_pkg::pfbu_op_e op, pfbu_pkg::pfbu_cond_e cc, pfbu_pkg::pfbu_src_e s,
                      logic [7:0] i8, logic [15:0] r16, logic [15:0] exp);
        ins(op, cc, s, i8, r16);
        instr_valid <= 0;
        @(posedge core_clk);
        chk(prog_addr, exp);
        pa = exp;
    endtask
    function automatic logic [15:0] rel(logic [7:0] i);
        rel = pa + 16'h0001 + {{8{i[7]}}, i};
    endfunction
    // drives flags so that condition c evaluates to t
    task automatic setf(int c, logic t);
        carry_flag <= (c == 2) ^ t;
        equals_flag <= (c == 7) ^ t;
        acc_value <= (c == 5) ? {t, 15'h0000} : {15'h0000, (c == 3) ^ t};
    endtask
    // ==========================================================
    // scenarios
    task automatic t_jumps();
        pa = 16'h0000;
        apb(0, pfbu_pkg::OFS_IP, 0);
        chk(rd, 32'h0000_0001);
        apb(0, 8'h1C, 0);
        chk({31'h0, err}, 1);
        chk(rd, 0);
        go(JMP, ALW, IMM, 8'h7F, 0, rel(8'h7F));
        go(JMP, ALW, IMM, 8'h80, 0, rel(8'h80));
        ins(PFX, ALW, IMM, 8'h12, 0);
        go(JMP, ALW, IMM, 8'h34, 0, 16'h1234);
        go(JMP, ALW, R16, 0, 16'hABCD, 16'hABCD);
        ins(PFX, ALW, IMM, 8'h56, 0);
        go(JMP, ALW, R8, 0, 16'hFF78, 16'h5678);
        go(JMP, ALW, R8, 0, 16'hFF9A, 16'h009A);
        go(JMP, ALW, IMM, 8'h02, 0, rel(8'h02));
        apb(0, pfbu_pkg::OFS_IP, 0);
        chk(rd, {16'h0000, pa + 16'h0001});
        for (int c = 1; c < 8; c++) begin
            for (int t = 0; t < 2; t++) begin
                setf(c, t[0]);
                ret = t ? rel(8'h10) : pa + 16'h0001;
                go(JMP, pfbu_pkg::pfbu_cond_e'(c), IMM, 8'h10, 0, ret);
            end
        end
        equals_flag <= 1;
        go(JMP, pfbu_pkg::PFBU_CC_E, R16, 0, 16'h7777, pa + 16'h0001);
        apb(0, pfbu_pkg::OFS_STATUS, 0);
        chk(rd[pfbu_pkg::ST_ILLEGAL], 1);
    endtask
    task automatic t_returns();
        go(CALL, ALW, IMM, 8'h05, 0, rel(8'h05));
        chk(stack_pop_data, pa - 16'h0005);
        go(RET, ALW, IMM, 0, 0, pa - 16'h0005);
        for (int c = 1; c < 6; c++) begin
            ret = pa + 16'h0001;
            setf(c, 0);
            go(CALL, ALW, R16, 0, 16'h4000, 16'h4000);
            go(RET, pfbu_pkg::pfbu_cond_e'(c), IMM, 0, 0, 16'h4001);
            chk(depth, 1);
            setf(c, 1);
            go(RET, pfbu_pkg::pfbu_cond_e'(c), IMM, 0, 0, ret);
            chk(depth, 0);
        end
        ret = pa + 16'h0001;
        setf(1, 0);
        go(CALL, ALW, R16, 0, 16'h5000, 16'h5000);
        go(RETI, pfbu_pkg::PFBU_CC_C, IMM, 0, 0, 16'h5001);
        chk({depth[1:0], interrupt_priority_state}, {2'h1, pfbu_pkg::IPS_RST});
        setf(1, 1);
        go(RETI, pfbu_pkg::PFBU_CC_C, IMM, 0, 0, ret);
        chk({depth[1:0], interrupt_priority_state}, {2'h0, pfbu_pkg::IPS_RETI});
    endtask
    task automatic t_loops();
        apb(1, pfbu_pkg::OFS_LC0, 32'h0000_0003);
        apb(1, pfbu_pkg::OFS_LC1, 32'h0000_0005);
        for (int k = 2; k >= 0; k--) begin
            go(DJNZ, ALW, R16, 0, 16'h0200, k ? 16'h0200 : pa + 16'h0001);
        end
        apb(0, pfbu_pkg::OFS_LC0, 0);
        chk(rd, 0);
        apb(0, pfbu_pkg::OFS_LC1, 0);
        chk(rd, 5);
        instr_lc_sel <= 1;
        ins(PFX, ALW, IMM, 8'h3C, 0);
        go(DJNZ, ALW, IMM, 8'h21, 0, 16'h3C21);
        apb(0, pfbu_pkg::OFS_LC1, 0);
        chk(rd, 4);
    endtask
    task automatic t_ctrl();
        apb(1, pfbu_pkg::OFS_CTRL, 0);
        chk(instr_ready, 0);
        go(JMP, ALW, R16, 0, 16'h7000, pa);
        apb(1, pfbu_pkg::OFS_CTRL, 1);
        apb(1, pfbu_pkg::OFS_PFX, 32'h0000_0077);
        go(JMP, ALW, IMM, 8'h01, 0, 16'h7701);
        apb(1, pfbu_pkg::OFS_STATUS, 32'h0000_0020);
        apb(0, pfbu_pkg::OFS_STATUS, 0);
        chk(rd[pfbu_pkg::ST_ILLEGAL], 0);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1;
        @(posedge core_clk);
        t_jumps();
        t_returns();
        t_loops();
        t_ctrl();
        stop_test();
    end
endmodule
